// *** design/cgi_defs.svh ***
// Purpose: Constants of the clock generator interrupt and clock output block
// Assumes: 16-bit register port, word index addressing
// Notes: Offsets are register indices on the plain port
//
// Behaviour
// - The second high-speed oscillator gain code applies only in crystal or ceramic mode, 0x3 max and 0x0 min.
// - The second high-speed wait code 0x0 to 0x7 selects 4, 16, 64, 256, 1024, 4096, 16384 or 65536 clocks.
// - Bit 5 flags a low-speed oscillator stop and bit 4 a finished trim; each reads 1 while pending.
// - Writing 1 to a flag clears it and writing 0 leaves it alone.
// - Bits 2, 1 and 0 flag the end of the wait of the second high-speed, low-speed and internal oscillators.
// - The internal oscillator stable flag reads 0 after reset although that clock is already stable.
// - Enable bits 5 and 4 pass the stop and trim-done interrupts when 1 and block them when 0.
// - Enable bits 2, 1 and 0 pass or block the three stable interrupts.
// - Source code 0 to 3 picks internal, low-speed, second high-speed or system clock, the last undivided only.
// - Internal and second high-speed sources divide by two to the power of the code, 1/1 to 1/128.
// - Low-speed codes 0 to 3 give 1/1 to 1/8 and codes 4 to 7 give 1/256, 1/1024, 1/4096 and 1/32768.
// - With the system clock as source the output stops in sleep and halt standby.
// - The output enable bit drives the divided clock to the pin when 1 and holds the pin low when 0.
// - Enable changes are not aligned to the divided clock, so the pin may glitch at that moment.
`ifndef CGI_DEFS_SVH
`define CGI_DEFS_SVH

`define CGI_IDX_HS2_CFG 4'h0
`define CGI_IDX_FLAGS 4'h1
`define CGI_IDX_ENABLES 4'h2
`define CGI_IDX_CLKOUT 4'h3

`define CGI_FLAG_MASK 6'h37
`define CGI_RST_GAIN 2'h1
`define CGI_RST_WAIT 3'h6
`define CGI_HS2_WAIT_BASE 17'h00004
`define CGI_MODE_CRYSTAL 2'h2

`define CGI_SRC_INTERNAL 2'h0
`define CGI_SRC_LOWSPEED 2'h1
`define CGI_SRC_HS2 2'h2
`define CGI_SRC_SYSTEM 2'h3

`endif

// *** design/cgi_pkg.sv ***
// Purpose: Types of the clock generator interrupt and clock output block
// Assumes: Constants come from cgi_defs.svh
// Notes: All state of the top module is one packed struct
package cgi_pkg;

    typedef struct packed {
        logic [1:0] gain;
        logic [2:0] wsel;
        logic [5:0] flags;
        logic [5:0] ens;
        logic [2:0] div;
        logic [1:0] src;
        logic fen;
        logic [15:0] rdata;
        logic irq;
        logic pin;
        logic gain_act;
        logic [3:0] prev;
        logic [14:0] div_cnt;
        logic [16:0] wait_cnt;
        logic wait_done;
    } cgi_state_type;

endpackage

// *** design/cgi_top.sv ***
// Purpose: Oscillator setting, interrupt causes and divided clock output
// Assumes: Oscillator clocks arrive as levels synchronous to ref_clk_i and slower than half its rate
// Notes: Low-speed and internal wait ends, stop and trim-done arrive as one-cycle pulses
`timescale 1ns/1ps
`include "cgi_defs.svh"

module cgi_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic internal_osc_clk_i,
    input wire logic lowspeed_osc_clk_i,
    input wire logic hs2_osc_clk_i,
    input wire logic system_clk_i,
    input wire logic standby_i,
    input wire logic hs2_osc_en_i,
    input wire logic [1:0] hs2_mode_i,
    input wire logic lowspeed_stop_i,
    input wire logic trim_done_i,
    input wire logic lowspeed_stable_i,
    input wire logic internal_stable_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    output logic clk_out_pin_o,
    output logic [1:0] hs2_gain_o,
    output logic hs2_gain_act_o,
    output logic [2:0] hs2_wait_sel_o
);
    import cgi_pkg::*;

    cgi_state_type st_ff;
    cgi_state_type nxt_st;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [16:0] wait_len(input logic [2:0] sel);
        wait_len = 17'(`CGI_HS2_WAIT_BASE << {sel, 1'b0});
    endfunction

    // Returns the number of halvings; 0 passes the source straight through
    function automatic logic [3:0] div_shift(input logic [1:0] src, input logic [2:0] code);
        div_shift = {1'b0, code};
        if (src == `CGI_SRC_SYSTEM) begin
            div_shift = 4'h0;
        end else if (src == `CGI_SRC_LOWSPEED && code[2]) begin
            case (code[1:0])
                2'h0: div_shift = 4'h8;
                2'h1: div_shift = 4'ha;
                2'h2: div_shift = 4'hc;
                default: div_shift = 4'hf;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [5:0] ev;
    logic [3:0] shift;
    logic divided;

    always_comb begin
        nxt_st = st_ff;
        lvl = {system_clk_i, hs2_osc_clk_i, lowspeed_osc_clk_i, internal_osc_clk_i};
        rise = lvl & ~st_ff.prev;
        nxt_st.prev = lvl;
        ev = 6'h00;
        // Register writes
        if (wr_i) begin
            case (addr_i)
                `CGI_IDX_HS2_CFG: begin
                    nxt_st.gain = wdata_i[5:4];
                    nxt_st.wsel = wdata_i[2:0];
                end
                `CGI_IDX_FLAGS: begin
                    nxt_st.flags = st_ff.flags & ~(wdata_i[5:0] & `CGI_FLAG_MASK);
                end
                `CGI_IDX_ENABLES: begin
                    nxt_st.ens = wdata_i[5:0] & `CGI_FLAG_MASK;
                end
                `CGI_IDX_CLKOUT: begin
                    nxt_st.div = wdata_i[6:4];
                    nxt_st.src = wdata_i[3:2];
                    nxt_st.fen = wdata_i[0];
                end
                default: begin
                end
            endcase
        end
        // Second high-speed stabilisation wait, counted in its own clock edges
        if (!hs2_osc_en_i) begin
            nxt_st.wait_cnt = 17'h00000;
            nxt_st.wait_done = 1'b0;
        end else if (rise[2] && !st_ff.wait_done) begin
            if (st_ff.wait_cnt == 17'(wait_len(st_ff.wsel) - 17'h00001)) begin
                nxt_st.wait_done = 1'b1;
                ev[2] = 1'b1;
            end else begin
                nxt_st.wait_cnt = 17'(st_ff.wait_cnt + 17'h00001);
            end
        end
        ev[1] = lowspeed_stable_i;
        ev[0] = internal_stable_i;
        ev[4] = trim_done_i;
        ev[5] = lowspeed_stop_i;
        // Set after clear so a same-cycle event is not lost
        nxt_st.flags = nxt_st.flags | ev;
        // Read data stands only in the cycle after the strobe
        nxt_st.rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                `CGI_IDX_HS2_CFG: nxt_st.rdata = {10'h000, st_ff.gain, 1'b0, st_ff.wsel};
                `CGI_IDX_FLAGS: nxt_st.rdata = {10'h000, st_ff.flags};
                `CGI_IDX_ENABLES: nxt_st.rdata = {10'h000, st_ff.ens};
                `CGI_IDX_CLKOUT: nxt_st.rdata = {9'h000, st_ff.div, st_ff.src, 1'b0, st_ff.fen};
                default: nxt_st.rdata = 16'h0000;
            endcase
        end
        // Clock output divider; the counter runs on the chosen source edges
        if (rise[st_ff.src]) begin
            nxt_st.div_cnt = 15'(st_ff.div_cnt + 15'h0001);
        end
        shift = div_shift(st_ff.src, st_ff.div);
        divided = (shift == 4'h0) ? lvl[st_ff.src] : st_ff.div_cnt[4'(shift - 4'h1)];
        // Enable gates the pin directly, not aligned to the divided clock
        nxt_st.pin = st_ff.fen & divided;
        if (st_ff.src == `CGI_SRC_SYSTEM && standby_i) begin
            nxt_st.pin = 1'b0;
        end
        nxt_st.gain_act = (hs2_mode_i == `CGI_MODE_CRYSTAL);
        nxt_st.irq = |(nxt_st.flags & nxt_st.ens);
        if (rst_i) begin
            nxt_st = '0;
            nxt_st.gain = `CGI_RST_GAIN;
            nxt_st.wsel = `CGI_RST_WAIT;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || ce_i) begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_o = st_ff.rdata;
    assign irq_o = st_ff.irq;
    assign clk_out_pin_o = st_ff.pin;
    assign hs2_gain_o = st_ff.gain;
    assign hs2_gain_act_o = st_ff.gain_act;
    assign hs2_wait_sel_o = st_ff.wsel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence flag_clear_s;
        ce_i && wr_i && addr_i == `CGI_IDX_FLAGS && wdata_i[5] && !lowspeed_stop_i;
    endsequence

    sequence flag_race_s;
        ce_i && wr_i && addr_i == `CGI_IDX_FLAGS && wdata_i[4] && trim_done_i;
    endsequence

    sequence wait_end_s;
        ce_i && hs2_osc_en_i && rise[2] && !st_ff.wait_done
            && st_ff.wait_cnt == 17'(wait_len(st_ff.wsel) - 17'h00001);
    endsequence

    w1c_clear_a: assert property (flag_clear_s |=> !st_ff.flags[5])
        else $error("flag not cleared by write of one");
    set_wins_a: assert property (flag_race_s |=> st_ff.flags[4])
        else $error("event lost against clear");
    hs2_stable_a: assert property (wait_end_s |=> st_ff.flags[2] && st_ff.wait_done)
        else $error("stable flag missing at end of wait");
    irq_level_a: assert property ($past(ce_i) |-> irq_o == |(st_ff.flags & st_ff.ens))
        else $error("interrupt level mismatch");
    flag_read_a: assert property (ce_i && rd_i && addr_i == `CGI_IDX_FLAGS
        |=> rdata_o == {10'h000, $past(st_ff.flags)})
        else $error("flag read value wrong");
    reset_vals_a: assert property (@(posedge ref_clk_i) $past(rst_i)
        |-> st_ff.flags == 6'h00 && st_ff.ens == 6'h00 && st_ff.div == 3'h0 && !st_ff.fen)
        else $error("reset values wrong");
    pin_off_a: assert property (!st_ff.fen && ce_i |=> !clk_out_pin_o)
        else $error("pin driven while output disabled");
    sys_stop_a: assert property (ce_i && st_ff.src == `CGI_SRC_SYSTEM && standby_i |=> !clk_out_pin_o)
        else $error("system clock output during standby");
    gain_act_a: assert property (ce_i |=> hs2_gain_act_o == ($past(hs2_mode_i) == `CGI_MODE_CRYSTAL))
        else $error("gain activity wrong for mode");

    // ------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------
    sequence rd_cfg_s;
        ce_i && rd_i && addr_i == `CGI_IDX_HS2_CFG;
    endsequence

    sequence rd_en_s;
        ce_i && rd_i && addr_i == `CGI_IDX_ENABLES;
    endsequence

    sequence rd_out_s;
        ce_i && rd_i && addr_i == `CGI_IDX_CLKOUT;
    endsequence

    sequence wr_cfg_s;
        ce_i && wr_i && addr_i == `CGI_IDX_HS2_CFG;
    endsequence

    sequence wr_en_s;
        ce_i && wr_i && addr_i == `CGI_IDX_ENABLES;
    endsequence

    sequence wr_out_s;
        ce_i && wr_i && addr_i == `CGI_IDX_CLKOUT;
    endsequence

    sequence wr_flags_s;
        ce_i && wr_i && addr_i == `CGI_IDX_FLAGS;
    endsequence

    cfg_read_a: assert property (rd_cfg_s |=> rdata_o == {10'h000, $past(st_ff.gain), 1'b0, $past(st_ff.wsel)})
        else $error("config read value wrong");
    en_read_a: assert property (rd_en_s |=> rdata_o == {10'h000, $past(st_ff.ens)})
        else $error("enable read value wrong");
    out_read_a: assert property (rd_out_s
        |=> rdata_o == {9'h000, $past(st_ff.div), $past(st_ff.src), 1'b0, $past(st_ff.fen)})
        else $error("clock out read value wrong");
    // Read data must not linger, a stale word would look like a second read
    read_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside its cycle");
    unmapped_read_a: assert property (ce_i && rd_i && addr_i > `CGI_IDX_CLKOUT |=> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    gain_write_a: assert property (wr_cfg_s |=> hs2_gain_o == $past(wdata_i[5:4]))
        else $error("gain write lost");
    wsel_write_a: assert property (wr_cfg_s |=> hs2_wait_sel_o == $past(wdata_i[2:0]))
        else $error("wait select write lost");
    en_write_a: assert property (wr_en_s |=> st_ff.ens == $past(wdata_i[5:0] & `CGI_FLAG_MASK))
        else $error("enable write lost");
    out_write_a: assert property (wr_out_s
        |=> st_ff.div == $past(wdata_i[6:4]) && st_ff.src == $past(wdata_i[3:2]) && st_ff.fen == $past(wdata_i[0]))
        else $error("clock out write lost");
    reserved_zero_a: assert property (!st_ff.flags[3] && !st_ff.ens[3])
        else $error("reserved bit set");
    ce_freeze_a: assert property (!ce_i |=> $stable(st_ff))
        else $error("state moved while clock enable low");

    // ------------------------------------------------------------
    // Interrupt checks
    // ------------------------------------------------------------
    flag_keep_a: assert property (wr_flags_s ##0 (!wdata_i[2] && st_ff.flags[2]) |=> st_ff.flags[2])
        else $error("flag lost on write of zero");
    stop_set_a: assert property (ce_i && lowspeed_stop_i |=> st_ff.flags[5])
        else $error("stop flag not set");
    trim_set_a: assert property (ce_i && trim_done_i |=> st_ff.flags[4])
        else $error("trim flag not set");
    ls_stable_a: assert property (ce_i && lowspeed_stable_i |=> st_ff.flags[1])
        else $error("low-speed stable flag not set");
    int_stable_a: assert property (ce_i && internal_stable_i |=> st_ff.flags[0])
        else $error("internal stable flag not set");
    int_reset_a: assert property ($past(rst_i) |-> !st_ff.flags[0] && !irq_o)
        else $error("internal stable flag set after reset");
    irq_stop_a: assert property (ce_i && lowspeed_stop_i && st_ff.ens[5] |=> irq_o)
        else $error("enabled stop interrupt missing");
    irq_stable_a: assert property (ce_i && internal_stable_i && st_ff.ens[0] |=> irq_o)
        else $error("enabled stable interrupt missing");
    irq_block_a: assert property (ce_i && !wr_i && st_ff.ens == 6'h00 |=> !irq_o)
        else $error("interrupt with all enables off");

    // ------------------------------------------------------------
    // Stabilisation wait checks
    // ------------------------------------------------------------
    sequence wait_step_s;
        ce_i && hs2_osc_en_i && rise[2] && !st_ff.wait_done
            && st_ff.wait_cnt != 17'(wait_len(st_ff.wsel) - 17'h00001);
    endsequence

    sequence wait_off_s;
        ce_i && !hs2_osc_en_i;
    endsequence

    wait_step_a: assert property (wait_step_s
        |=> st_ff.wait_cnt == 17'($past(st_ff.wait_cnt) + 17'h00001) && !st_ff.wait_done)
        else $error("wait count step wrong");
    wait_restart_a: assert property (wait_off_s |=> st_ff.wait_cnt == 17'h00000 && !st_ff.wait_done)
        else $error("wait not restarted");
    wait_hold_a: assert property (ce_i && hs2_osc_en_i && st_ff.wait_done |=> st_ff.wait_done)
        else $error("wait end lost while running");

    // ------------------------------------------------------------
    // Clock output checks
    // ------------------------------------------------------------
    sequence pin_pass_s;
        ce_i && st_ff.fen && shift == 4'h0 && !(st_ff.src == `CGI_SRC_SYSTEM && standby_i);
    endsequence

    sequence pin_div_s;
        ce_i && st_ff.fen && shift != 4'h0;
    endsequence

    pin_pass_a: assert property (pin_pass_s |=> clk_out_pin_o == $past(lvl[st_ff.src]))
        else $error("undivided output wrong");
    pin_div_a: assert property (pin_div_s |=> clk_out_pin_o == $past(st_ff.div_cnt[4'(shift - 4'h1)]))
        else $error("divided output wrong");
    sys_undiv_a: assert property (st_ff.src == `CGI_SRC_SYSTEM |-> shift == 4'h0)
        else $error("system clock divided");
    hs2_max_a: assert property (st_ff.src == `CGI_SRC_HS2 && st_ff.div == 3'h7 |-> shift == 4'h7)
        else $error("deepest division wrong");
    ls_deep_a: assert property (st_ff.src == `CGI_SRC_LOWSPEED && st_ff.div == 3'h7 |-> shift == 4'hf)
        else $error("deepest low-speed division wrong");
    ls_low_a: assert property (st_ff.src == `CGI_SRC_LOWSPEED && st_ff.div == 3'h3 |-> shift == 4'h3)
        else $error("low-speed 1/8 wrong");
    div_count_a: assert property (ce_i && rise[st_ff.src]
        |=> st_ff.div_cnt == 15'($past(st_ff.div_cnt) + 15'h0001))
        else $error("divider count step wrong");

endmodule

// *** tb/cgi_tb.sv ***
// Purpose: Self-checking bench of the clock generator interrupt and clock out block
// Assumes: Oscillator sources share one bench clock of four reference cycles
// Notes: Low-speed divisions above 1/256 are left out to keep the run short
`timescale 1ns/1ps
`include "cgi_defs.svh"

module tb;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] sc = 2'h0;
    logic hs2_clk = 1'b0;
    logic hs2_run = 1'b0;
    logic standby_i = 1'b0;
    logic hs2_en = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] evt = 4'h0;
    logic [15:0] rdata_o;
    logic irq_o;
    logic pin;
    logic gact;
    logic [1:0] gain;
    logic [2:0] wsel;
    int error_cnt = 0;
    int num_checks = 0;
    int pos[4] = '{0, 1, 4, 5};

    // ----------------------------------------
    // Clocks and design
    // ----------------------------------------
    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) sc <= sc + 2'h1;

    cgi_top cgi_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .internal_osc_clk_i(sc[1]), .lowspeed_osc_clk_i(sc[1]),
        .hs2_osc_clk_i(hs2_run ? sc[1] : hs2_clk), .system_clk_i(sc[1] & ~standby_i), .standby_i(standby_i),
        .hs2_osc_en_i(hs2_en), .hs2_mode_i(mode), .lowspeed_stop_i(evt[3]), .trim_done_i(evt[2]),
        .lowspeed_stable_i(evt[1]), .internal_stable_i(evt[0]), .rdata_o(rdata_o), .irq_o(irq_o),
        .clk_out_pin_o(pin), .hs2_gain_o(gain), .hs2_gain_act_o(gact), .hs2_wait_sel_o(wsel));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    // Strobe drops one edge later so back-to-back calls never drive it twice at once
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string name);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        check(name, exp, rdata_o);
        @(posedge ref_clk_i);
    endtask

    task automatic hs2_edges(input int n);
        repeat (n) begin
            hs2_clk <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
            hs2_clk <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask

    // First rise only aligns, so a divider change cannot shorten the measured period
    task automatic per(input logic [15:0] exp);
        int n;
        logic p;
        repeat (2) begin
            n = 0;
            do begin
                p = pin;
                @(posedge ref_clk_i);
                n++;
            end while (!(pin && !p) && n < 40000);
        end
        check("clock out period", exp, n[15:0]);
    endtask

    task automatic quiet(input string name);
        int n;
        n = 0;
        repeat (4) @(posedge ref_clk_i);
        repeat (20) begin
            @(posedge ref_clk_i);
            if (pin) n++;
        end
        check(name, 16'h0000, n[15:0]);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdc(`CGI_IDX_HS2_CFG, 16'h0016, "hs2 config");
        rdc(`CGI_IDX_FLAGS, 16'h0000, "flags");
        rdc(`CGI_IDX_ENABLES, 16'h0000, "enables");
        rdc(`CGI_IDX_CLKOUT, 16'h0000, "clock out control");
        check("irq", 16'h0000, {15'h0, irq_o});
        check("gain active", 16'h0000, {15'h0, gact});
        $display("test reset done");
    endtask

    task automatic t_regs;
        mode <= `CGI_MODE_CRYSTAL;
        wr(`CGI_IDX_HS2_CFG, 16'hffff);
        rdc(`CGI_IDX_HS2_CFG, 16'h0037, "hs2 config");
        check("gain", 16'h0003, {14'h0, gain});
        check("gain active", 16'h0001, {15'h0, gact});
        check("wait select", 16'h0007, {13'h0, wsel});
        wr(`CGI_IDX_ENABLES, 16'hffff);
        rdc(`CGI_IDX_ENABLES, 16'h0037, "enables");
        wr(`CGI_IDX_CLKOUT, 16'hffff);
        rdc(`CGI_IDX_CLKOUT, 16'h007d, "clock out control");
        wr(4'h9, 16'hffff);
        rdc(4'h9, 16'h0000, "unmapped");
        wr(`CGI_IDX_ENABLES, 16'h0000);
        ce <= 1'b0;
        wr(`CGI_IDX_ENABLES, 16'h0037);
        ce <= 1'b1;
        rdc(`CGI_IDX_ENABLES, 16'h0000, "frozen enables");
        $display("test registers done");
    endtask

    task automatic t_irq;
        logic [15:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 16'h0001 << pos[i];
            evt[i] <= 1'b1;
            @(posedge ref_clk_i);
            evt[i] <= 1'b0;
            rdc(`CGI_IDX_FLAGS, b, "flag set");
            check("masked irq", 16'h0000, {15'h0, irq_o});
            wr(`CGI_IDX_ENABLES, b);
            rdc(`CGI_IDX_ENABLES, b, "enable");
            check("irq", 16'h0001, {15'h0, irq_o});
            wr(`CGI_IDX_FLAGS, ~b);
            rdc(`CGI_IDX_FLAGS, b, "flag kept");
            wr(`CGI_IDX_FLAGS, b);
            rdc(`CGI_IDX_FLAGS, 16'h0000, "flag cleared");
            check("irq cleared", 16'h0000, {15'h0, irq_o});
            wr(`CGI_IDX_ENABLES, 16'h0000);
        end
        $display("test interrupts done");
    endtask

    task automatic t_wait;
        for (int c = 0; c < 2; c++) begin
            wr(`CGI_IDX_HS2_CFG, 16'h0010 | 16'(c));
            hs2_en <= 1'b1;
            hs2_edges((4 << (2 * c)) - 1);
            rdc(`CGI_IDX_FLAGS, 16'h0000, "wait early");
            hs2_edges(1);
            rdc(`CGI_IDX_FLAGS, 16'h0004, "wait end");
            hs2_en <= 1'b0;
            wr(`CGI_IDX_FLAGS, 16'h0004);
        end
        $display("test hs2 wait done");
    endtask

    task automatic t_clkout;
        hs2_run <= 1'b1;
        wr(`CGI_IDX_CLKOUT, 16'h0001);
        per(16'd4);
        wr(`CGI_IDX_CLKOUT, 16'h0031);
        per(16'd32);
        wr(`CGI_IDX_CLKOUT, 16'h0079);
        per(16'd512);
        wr(`CGI_IDX_CLKOUT, 16'h0035);
        per(16'd32);
        wr(`CGI_IDX_CLKOUT, 16'h0045);
        per(16'd1024);
        wr(`CGI_IDX_CLKOUT, 16'h005d);
        per(16'd4);
        standby_i <= 1'b1;
        quiet("standby output");
        standby_i <= 1'b0;
        wr(`CGI_IDX_CLKOUT, 16'h0000);
        quiet("disabled output");
        $display("test clock out done");
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_irq();
        t_wait();
        t_clkout();
        finish_test();
    end

    // Expected run is near 2600 cycles
    initial begin
        #200000;
        error_cnt++;
        $display("watchdog expired");
        finish_test();
    end
endmodule
